/* File: rtl/ebo_pkg.sv */
package ebo_pkg;

   // ****************************************************************
   // register offsets (byte addresses, one word each)
   // ****************************************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_BP0 = 8'h08;
   localparam logic [7:0] OFS_BP1 = 8'h0C;
   localparam logic [7:0] OFS_BP2 = 8'h10;
   localparam logic [7:0] OFS_MAP = 8'h14;
   localparam logic [7:0] OFS_CYCCNT = 8'h18;
   localparam logic [7:0] OFS_TRIDX = 8'h1C;
   localparam logic [7:0] OFS_TRLO = 8'h20;
   localparam logic [7:0] OFS_TRHI = 8'h24;
   localparam logic [7:0] OFS_TRCNT = 8'h28;
   localparam logic [7:0] OFS_SNAP = 8'h2C;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h30;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h34;
   localparam logic [7:0] OFS_IRQ_EN = 8'h38;
   localparam logic [7:0] OFS_MEM_PTR = 8'h3C;
   localparam logic [7:0] OFS_MEM_DATA = 8'h40;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int CTRL_GO = 0;
   localparam int CTRL_STEP = 1;
   localparam int CTRL_BRK_EN = 2;
   localparam int CTRL_INJECT = 3;
   localparam int CTRL_CNT_CLR = 4;
   localparam int CTRL_CLK_LO = 5;
   localparam int CTRL_STOP = 7;
   localparam int BP_EN = 15;
   localparam int MAP_DATA = 16;
   localparam int MEM_SEL_DATA = 12;
   localparam int IRQ_BREAK = 0;
   localparam int IRQ_STEP = 1;
   localparam int IRQ_MATCH = 2;

   // ****************************************************************
   // sizes and reset values
   // ****************************************************************
   localparam int BP_W = 15;
   localparam int TRACE_W = 44;
   localparam int TRACE_DEPTH = 255;
   localparam int PMEM_DEPTH = 4096;
   localparam int DMEM_DEPTH = 256;
   localparam int PAGES = 16;
   localparam logic [16:0] RST_MAP = 17'h00000;
   localparam logic [15:0] RST_BP = 16'h0000;
   localparam logic [2:0] RST_IRQ_EN = 3'h0;

   // emulation clock source select codes
   localparam logic [1:0] CLK_11M = 2'h0;
   localparam logic [1:0] CLK_5M5 = 2'h1;
   localparam logic [1:0] CLK_EXT = 2'h2;

   typedef enum logic [1:0] {
      EMU_HALT = 2'b00,
      EMU_RUN = 2'b01,
      EMU_STEP = 2'b10
   } ebo_emu_e;

endpackage

/* File: rtl/ebo_bkpt.sv */
`timescale 1ns/1ns
`default_nettype none
module ebo_bkpt
   import ebo_pkg::*;
(
   // compared value: status above address
   input wire logic [ebo_pkg::BP_W-1:0] val_i,
   // breakpoint registers: enable above compare value
   input wire logic [15:0] bp0_i,
   input wire logic [15:0] bp1_i,
   input wire logic [15:0] bp2_i,
   // per-register hit
   output logic [2:0] hit_o
);

   function automatic logic bp_hit(input logic [15:0] bp,
                                   input logic [BP_W-1:0] v);
      bp_hit = bp[BP_EN] && (bp[BP_W-1:0] == v);
   endfunction

   always_comb begin
      hit_o[0] = bp_hit(bp0_i, val_i);
      hit_o[1] = bp_hit(bp1_i, val_i);
      hit_o[2] = bp_hit(bp2_i, val_i);
   end

endmodule
`default_nettype wire

/* File: rtl/ebo_trace.sv */
`timescale 1ns/1ns
`default_nettype none
module ebo_trace
   import ebo_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // capture side
   input wire logic wr_i,
   input wire logic [ebo_pkg::TRACE_W-1:0] wdata_i,
   // read side, index 0 is the oldest entry
   input wire logic [7:0] rd_idx_i,
   output logic [ebo_pkg::TRACE_W-1:0] rdata_o,
   output logic [7:0] count_o
);

   localparam logic [7:0] LAST = 8'(TRACE_DEPTH - 1);
   localparam logic [7:0] FULL = 8'(TRACE_DEPTH);

   logic [TRACE_W-1:0] mem_q [0:TRACE_DEPTH-1];
   logic [7:0] wptr_q;
   logic [7:0] count_q;
   logic [7:0] base;
   logic [8:0] sum;
   logic [7:0] phys;

   // modulo-255 wrap; the index is never above 254 when valid
   function automatic logic [7:0] wrap(input logic [8:0] s);
      wrap = (s >= 9'(TRACE_DEPTH)) ? 8'(s - 9'(TRACE_DEPTH)) : s[7:0];
   endfunction

   always_ff @(posedge clk_i) begin
      if (wr_i) begin
         mem_q[wptr_q] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wptr_q <= 8'h00;
         count_q <= 8'h00;
      end else if (wr_i) begin
         wptr_q <= (wptr_q == LAST) ? 8'h00 : wptr_q + 8'h01;
         if (count_q != FULL) begin
            count_q <= count_q + 8'h01;
         end
      end
   end

   always_comb begin
      base = (count_q == FULL) ? wptr_q : 8'h00;
      sum = {1'b0, base} + {1'b0, rd_idx_i};
      phys = wrap(sum);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o <= '0;
      end else begin
         rdata_o <= mem_q[phys];
      end
   end

   assign count_o = count_q;

endmodule
`default_nettype wire

/* File: rtl/ebo_top.sv */
// What this block does
// - the block is a bus peripheral taking host commands and posting replies in registers the host reads.
// - three loadable 15-bit breakpoint registers hold the compare values.
// - while emulating, address and status are compared to the breakpoints and a match stops emulation.
// - a match output signals every breakpoint match.
// - stopping on a match can be disabled while the match output keeps pulsing.
// - at the end of emulation trace, processor state and block status are made available to the host.
// - 4K of replacement program memory in sixteen 256-byte pages is fetched at full speed.
// - one 256-byte page of replacement data memory can stand in for target data memory.
// - a host-loaded map steers each 256-byte segment to replacement or target memory.
// - the host selects an internal emulation clock of 11 MHz or 5.5 MHz.
// - the internal clock can be replaced by a target clock of 1.0 to 8.0 MHz supplied by the target.
// - step mode runs one instruction and halts so registers can be dumped.
// - on host command an emulated interrupt is injected into the processor.
// - each executed instruction cycle writes a 44-bit entry, keeping the last 255.
// - instruction cycles are counted in a counter the host can reset.
`timescale 1ns/1ns
`default_nettype none
module ebo_top
   import ebo_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   // emulated processor observation
   input wire logic cyc_i,
   input wire logic [11:0] addr_i,
   input wire logic [2:0] status_i,
   input wire logic [ebo_pkg::TRACE_W-1:0] trace_i,
   input wire logic [31:0] cpu_state_i,
   // emulated processor control
   output logic run_o,
   output logic [1:0] clk_sel_o,
   output logic emu_int_o,
   output logic match_o,
   // program memory overlay
   input wire logic [11:0] pm_addr_i,
   output logic [7:0] pm_data_o,
   output logic pm_repl_o,
   // data memory overlay
   input wire logic [7:0] dm_addr_i,
   input wire logic dm_we_i,
   input wire logic [7:0] dm_wdata_i,
   output logic [7:0] dm_data_o,
   output logic dm_repl_o
);

   // ****************************************************************
   // declarations
   // ****************************************************************
   ebo_emu_e state_q;
   logic run_q;
   logic brk_en_q;
   logic [1:0] clk_sel_q;
   logic [15:0] bp0_q;
   logic [15:0] bp1_q;
   logic [15:0] bp2_q;
   logic [16:0] map_q;
   logic [31:0] cyccnt_q;
   logic [7:0] tridx_q;
   logic [31:0] snap_q;
   logic [1:0] cause_q;
   logic [2:0] last_hit_q;
   logic [2:0] irq_stat_q;
   logic [2:0] irq_en_q;
   logic [12:0] mem_ptr_q;
   logic [7:0] pmem_q [0:PMEM_DEPTH-1];
   logic [7:0] dmem_q [0:DMEM_DEPTH-1];
   logic ack_q;
   logic [31:0] rdata_q;
   logic match_q;
   logic emu_int_q;
   logic irq_q;
   logic [7:0] pm_data_q;
   logic pm_repl_q;
   logic [7:0] dm_data_q;
   logic dm_repl_q;

   logic req;
   logic wr_fire;
   logic rd_fire;
   logic [31:0] wd;
   logic [2:0] hit;
   logic any_hit;
   logic emu_cyc;
   logic brk;
   logic step_done;
   logic halt_now;
   logic host_stop;
   logic [TRACE_W-1:0] tr_data;
   logic [7:0] tr_count;
   logic [31:0] rd_mux;
   logic dm_cpu_wr;

   // byte-lane merge of a write into a register's current value
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] sel);
      merge = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            merge[8*b +: 8] = nw[8*b +: 8];
         end
      end
   endfunction

   function automatic logic is_wr(input logic [7:0] ofs);
      is_wr = wr_fire && (wb_adr_i == ofs);
   endfunction

   // ****************************************************************
   // bus handshake
   // ****************************************************************
   // writes land on the edge where ack is seen high by the master
   assign req = wb_cyc_i && wb_stb_i;
   assign wr_fire = req && wb_we_i && ack_q;
   assign rd_fire = req && !wb_we_i && !ack_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req && !ack_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_q <= 32'h00000000;
      end else if (rd_fire) begin
         rdata_q <= rd_mux;
      end
   end

   // ****************************************************************
   // breakpoint compare and emulation events
   // ****************************************************************
   ebo_bkpt u_bkpt (
      .val_i({status_i, addr_i}),
      .bp0_i(bp0_q),
      .bp1_i(bp1_q),
      .bp2_i(bp2_q),
      .hit_o(hit)
   );

   assign emu_cyc = cyc_i && (state_q != EMU_HALT);
   assign any_hit = |hit;
   assign brk = emu_cyc && any_hit && brk_en_q;
   assign step_done = cyc_i && (state_q == EMU_STEP);
   // spelled out: a function reading module nets would leave this stale
   assign host_stop = wr_fire && (wb_adr_i == OFS_CTRL) && wd[CTRL_STOP];
   assign halt_now = brk || step_done || host_stop;
   assign wd = merge(32'h00000000, wb_dat_i, wb_sel_i);

   // ****************************************************************
   // emulation state
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= EMU_HALT;
         run_q <= 1'b0;
      end else begin
         case (state_q)
            EMU_HALT: begin
               if (is_wr(OFS_CTRL) && wd[CTRL_GO] && !wd[CTRL_STOP]) begin
                  state_q <= wd[CTRL_STEP] ? EMU_STEP : EMU_RUN;
                  run_q <= 1'b1;
               end
            end
            EMU_RUN: begin
               if (halt_now) begin
                  state_q <= EMU_HALT;
                  run_q <= 1'b0;
               end
            end
            EMU_STEP: begin
               if (halt_now) begin
                  state_q <= EMU_HALT;
                  run_q <= 1'b0;
               end
            end
            default: begin
               state_q <= EMU_HALT;
               run_q <= 1'b0;
            end
         endcase
      end
   end

   // ****************************************************************
   // control registers
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         brk_en_q <= 1'b1;
         clk_sel_q <= CLK_11M;
      end else if (is_wr(OFS_CTRL)) begin
         brk_en_q <= wd[CTRL_BRK_EN];
         if (wb_sel_i[0]) begin
            clk_sel_q <= wd[CTRL_CLK_LO +: 2];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bp0_q <= RST_BP;
         bp1_q <= RST_BP;
         bp2_q <= RST_BP;
      end else begin
         if (is_wr(OFS_BP0)) begin
            bp0_q <= 16'(merge({16'h0000, bp0_q}, wb_dat_i, wb_sel_i));
         end
         if (is_wr(OFS_BP1)) begin
            bp1_q <= 16'(merge({16'h0000, bp1_q}, wb_dat_i, wb_sel_i));
         end
         if (is_wr(OFS_BP2)) begin
            bp2_q <= 16'(merge({16'h0000, bp2_q}, wb_dat_i, wb_sel_i));
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         map_q <= RST_MAP;
      end else if (is_wr(OFS_MAP)) begin
         map_q <= 17'(merge({15'h0000, map_q}, wb_dat_i, wb_sel_i));
      end
   end

   // ****************************************************************
   // cycle counter and trace
   // ****************************************************************
   // clear beats a coincident count, so the first cycle after it is 1
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cyccnt_q <= 32'h00000000;
      end else if (is_wr(OFS_CTRL) && wd[CTRL_CNT_CLR]) begin
         cyccnt_q <= 32'h00000000;
      end else if (emu_cyc) begin
         cyccnt_q <= cyccnt_q + 32'h00000001;
      end
   end

   ebo_trace u_trace (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(emu_cyc),
      .wdata_i(trace_i),
      .rd_idx_i(tridx_q),
      .rdata_o(tr_data),
      .count_o(tr_count)
   );

   // reading the high half steps to the next entry for burst dumps
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tridx_q <= 8'h00;
      end else if (is_wr(OFS_TRIDX)) begin
         tridx_q <= wb_dat_i[7:0];
      end else if (req && !wb_we_i && ack_q && wb_adr_i == OFS_TRHI) begin
         tridx_q <= tridx_q + 8'h01;
      end
   end

   // ****************************************************************
   // halt snapshot
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         snap_q <= 32'h00000000;
         cause_q <= 2'h0;
         last_hit_q <= 3'h0;
      end else if (state_q != EMU_HALT && halt_now) begin
         snap_q <= cpu_state_i;
         cause_q <= {step_done, brk};
         last_hit_q <= emu_cyc ? hit : 3'h0;
      end
   end

   // ****************************************************************
   // processor side outputs
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         match_q <= 1'b0;
      end else begin
         match_q <= emu_cyc && any_hit;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         emu_int_q <= 1'b0;
      end else begin
         emu_int_q <= is_wr(OFS_CTRL) && wd[CTRL_INJECT];
      end
   end

   // ****************************************************************
   // replacement memories
   // ****************************************************************
   // the processor owns the data page while it writes; a host write in
   // the same cycle to the same page is dropped
   assign dm_cpu_wr = dm_we_i && map_q[MAP_DATA];

   always_ff @(posedge clk_i) begin
      if (is_wr(OFS_MEM_DATA) && !mem_ptr_q[MEM_SEL_DATA]) begin
         pmem_q[mem_ptr_q[11:0]] <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (dm_cpu_wr) begin
         dmem_q[dm_addr_i] <= dm_wdata_i;
      end else if (is_wr(OFS_MEM_DATA) && mem_ptr_q[MEM_SEL_DATA]) begin
         dmem_q[mem_ptr_q[7:0]] <= wb_dat_i[7:0];
      end
   end

   // data accesses step the pointer so host loads need no rewrite
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mem_ptr_q <= 13'h0000;
      end else if (is_wr(OFS_MEM_PTR)) begin
         mem_ptr_q <= wb_dat_i[12:0];
      end else if (req && ack_q && wb_adr_i == OFS_MEM_DATA) begin
         mem_ptr_q <= mem_ptr_q + 13'h0001;
      end
   end

   // one-cycle fetch latency; a full-speed cycle is far longer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pm_data_q <= 8'h00;
         pm_repl_q <= 1'b0;
         dm_data_q <= 8'h00;
         dm_repl_q <= 1'b0;
      end else begin
         pm_data_q <= pmem_q[pm_addr_i];
         pm_repl_q <= map_q[pm_addr_i[11:8]];
         dm_data_q <= dmem_q[dm_addr_i];
         dm_repl_q <= map_q[MAP_DATA];
      end
   end

   // ****************************************************************
   // interrupt status
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_q <= 3'h0;
      end else begin
         // set wins over a clear in the same cycle
         irq_stat_q <= (irq_stat_q & ~(is_wr(OFS_IRQ_CLR) ?
                        wd[2:0] : 3'h0)) |
                       {emu_cyc && any_hit,
                        state_q == EMU_STEP && step_done,
                        state_q == EMU_RUN && brk};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_en_q <= RST_IRQ_EN;
      end else if (is_wr(OFS_IRQ_EN)) begin
         irq_en_q <= wd[2:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(irq_stat_q & irq_en_q);
      end
   end

   // ****************************************************************
   // read multiplexer
   // ****************************************************************
   always_comb begin
      rd_mux = 32'h00000000;
      case (wb_adr_i)
         OFS_CTRL: begin
            rd_mux[CTRL_BRK_EN] = brk_en_q;
            rd_mux[CTRL_CLK_LO +: 2] = clk_sel_q;
            rd_mux[CTRL_STEP] = state_q == EMU_STEP;
         end
         OFS_STAT: begin
            rd_mux = {25'h0000000, last_hit_q, cause_q,
                      state_q};
         end
         OFS_BP0: rd_mux = {16'h0000, bp0_q};
         OFS_BP1: rd_mux = {16'h0000, bp1_q};
         OFS_BP2: rd_mux = {16'h0000, bp2_q};
         OFS_MAP: rd_mux = {15'h0000, map_q};
         OFS_CYCCNT: rd_mux = cyccnt_q;
         OFS_TRIDX: rd_mux = {24'h000000, tridx_q};
         OFS_TRLO: rd_mux = tr_data[31:0];
         OFS_TRHI: rd_mux = {20'h00000, tr_data[TRACE_W-1:32]};
         OFS_TRCNT: rd_mux = {24'h000000, tr_count};
         OFS_SNAP: rd_mux = snap_q;
         OFS_IRQ_STAT: rd_mux = {29'h00000000, irq_stat_q};
         OFS_IRQ_EN: rd_mux = {29'h00000000, irq_en_q};
         OFS_MEM_PTR: rd_mux = {19'h00000, mem_ptr_q};
         OFS_MEM_DATA: begin
            rd_mux[7:0] = mem_ptr_q[MEM_SEL_DATA] ?
                          dmem_q[mem_ptr_q[7:0]] :
                          pmem_q[mem_ptr_q[11:0]];
         end
         default: rd_mux = 32'h00000000;
      endcase
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdata_q;
   assign irq_o = irq_q;
   assign run_o = run_q;
   assign clk_sel_o = clk_sel_q;
   assign emu_int_o = emu_int_q;
   assign match_o = match_q;
   assign pm_data_o = pm_data_q;
   assign pm_repl_o = pm_repl_q;
   assign dm_data_o = dm_data_q;
   assign dm_repl_o = dm_repl_q;

endmodule
`default_nettype wire

/* File: tb/ebo_top_props.sv */
`timescale 1ns/1ns
`default_nettype none
module ebo_top_props
   import ebo_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   // emulation
   input wire logic cyc_i,
   input wire logic run_o,
   input wire logic [1:0] clk_sel_o,
   input wire logic emu_int_o,
   input wire logic match_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic ctrl_wr;
   assign ctrl_wr = wb_cyc_i && wb_ack_o && wb_we_i && wb_adr_i == OFS_CTRL;

   a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acked next cycle");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_match_cause: assert property (match_o |-> $past(cyc_i) && $past(run_o))
      else $error("match without a running cycle");
   a_inject_pulse: assert property (emu_int_o |=> !emu_int_o)
      else $error("inject pulse too long");
   a_go_runs: assert property (ctrl_wr && wb_dat_i[CTRL_GO]
      && !wb_dat_i[CTRL_STOP] && !run_o |=> run_o)
      else $error("go did not start emulation");
   a_stop_halts: assert property (ctrl_wr && wb_dat_i[CTRL_STOP] |=> !run_o)
      else $error("stop did not halt");
   a_halt_cause: assert property ($fell(run_o) && !$past(rst_i)
      |-> $past(cyc_i) || $past(ctrl_wr))
      else $error("halt without cycle or command");
   a_clk_sel_hold: assert property ($changed(clk_sel_o) && !$past(rst_i)
      |-> $past(ctrl_wr))
      else $error("clock select moved unasked");
endmodule

bind ebo_top ebo_top_props props_u (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
   .cyc_i(cyc_i), .run_o(run_o), .clk_sel_o(clk_sel_o),
   .emu_int_o(emu_int_o), .match_o(match_o));
`default_nettype wire

/* File: tb/ebo_cpu_model.sv */
`timescale 1ns/1ns
`default_nettype none
module ebo_cpu_model #(
   parameter logic [2:0] STATUS = 3'h2,
   parameter logic [31:0] STATE = 32'h12345678
) (
   // clock and control
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic [3:0] gap_i,
   input wire logic [11:0] base_i,
   // observed lines
   output logic cyc_o,
   output logic [11:0] addr_o,
   output logic [2:0] status_o,
   output logic [43:0] trace_o,
   output logic [31:0] state_o
);
   logic [3:0] wait_q;
   logic [11:0] addr_q;
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         cyc_o <= 1'b0;
         wait_q <= gap_i;
         addr_q <= base_i;
      end else if (cyc_o) begin
         cyc_o <= 1'b0;
         wait_q <= gap_i;
         addr_q <= addr_q + 12'h001;
      end else if (wait_q == 4'h0) begin
         cyc_o <= 1'b1;
      end else begin
         wait_q <= wait_q - 4'h1;
      end
   end
   // a halted cpu shows no stale address, so a stale match cannot pass
   assign addr_o = run_i ? addr_q : ~addr_q;
   assign status_o = STATUS;
   assign trace_o = {32'h0, addr_q};
   assign state_o = STATE;
endmodule
`default_nettype wire

/* File: tb/ebo_top_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module ebo_top_tb;
   import ebo_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00, dm_addr = 8'h00;
   logic [11:0] pm_addr = 12'h000, base = 12'h120;
   logic [3:0] gap = 4'h2;
   logic [31:0] wdat = 32'h0, q, dat_o, state;
   logic ack, irq, run, emu_int, match, pm_repl, dm_repl, c_cyc;
   logic dm_we = 1'b0;
   logic [1:0] clk_sel;
   logic [7:0] pm_data, dm_data;
   logic [11:0] c_addr;
   logic [2:0] c_stat;
   logic [43:0] trace;
   int mismatches = 0, n_tests = 0, cycles = 0, n;

   initial forever #50 clk_i = ~clk_i;

   ebo_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq_o(irq),
      .cyc_i(c_cyc), .addr_i(c_addr), .status_i(c_stat), .trace_i(trace),
      .cpu_state_i(state), .run_o(run), .clk_sel_o(clk_sel),
      .emu_int_o(emu_int), .match_o(match), .pm_addr_i(pm_addr),
      .pm_data_o(pm_data), .pm_repl_o(pm_repl), .dm_addr_i(dm_addr),
      .dm_we_i(dm_we), .dm_wdata_i(8'h3C), .dm_data_o(dm_data),
      .dm_repl_o(dm_repl));
   ebo_cpu_model cpu_u (.clk_i(clk_i), .rst_i(rst_i), .run_i(run),
      .gap_i(gap), .base_i(base), .cyc_o(c_cyc), .addr_o(c_addr),
      .status_o(c_stat), .trace_o(trace), .state_o(state));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic final_report();
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // held until the edge that samples ack, released there
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask

   task automatic wait_halt();
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (run === 1'b1 && n < 300);
      chk(32'(run), 32'h0);
   endtask

   task automatic count(input int c, ref logic s);
      n = 0;
      repeat (c) begin
         @(negedge clk_i);
         n += int'(s === 1'b1);
      end
   endtask

   task automatic irqx(input logic e);
      repeat (3) @(negedge clk_i);
      chk(32'(irq), 32'(e));
   endtask

   task automatic t_reset();
      rd(OFS_MAP, 32'h0);
      rd(OFS_BP0, 32'h0);
      rd(OFS_IRQ_EN, 32'h0);
      rd(8'h7C, 32'h0);
      wr(OFS_BP1, 32'hFFFF);
      rd(OFS_BP1, 32'hFFFF);
   endtask

   task automatic t_break();
      wr(OFS_BP0, 32'hA123);
      wr(OFS_IRQ_EN, 32'h7);
      wr(OFS_CTRL, 32'h5);
      wait_halt();
      rd(OFS_CYCCNT, 32'h4);
      rd(OFS_TRCNT, 32'h4);
      wr(OFS_TRIDX, 32'h3);
      rd(OFS_TRLO, 32'h123);
      rd(OFS_SNAP, 32'h12345678);
      bus(1'b0, OFS_STAT, 32'h0);
      chk(32'(q[6:2]), 32'h5);
      rd(OFS_IRQ_STAT, 32'h5);
      irqx(1'b1);
      wr(OFS_IRQ_EN, 32'h0);
      irqx(1'b0);
      wr(OFS_IRQ_EN, 32'h7);
      irqx(1'b1);
      wr(OFS_IRQ_CLR, 32'h7);
      irqx(1'b0);
   endtask

   task automatic t_match();
      @(posedge clk_i);
      gap <= 4'h0;
      wr(OFS_CTRL, 32'h1);
      count(40, match);
      chk(32'(n), 32'h1);
      chk(32'(run), 32'h1);
      wr(OFS_CTRL, 32'h80);
      wait_halt();
      @(posedge clk_i);
      gap <= 4'h2;
      wr(OFS_CTRL, 32'h7);
      wait_halt();
      bus(1'b0, OFS_STAT, 32'h0);
      chk(32'(q[3:2]), 32'h2);
      rd(OFS_IRQ_STAT, 32'h6);
      wr(OFS_CTRL, 32'hC);
      count(4, emu_int);
      chk(32'(n), 32'h1);
      wr(OFS_CTRL, 32'h14);
      rd(OFS_CYCCNT, 32'h0);
      for (int i = 0; i < 3; i++) begin
         wr(OFS_CTRL, (32'(i) << 5) | 32'h4);
         @(negedge clk_i);
         chk(32'(clk_sel), 32'(i));
      end
   endtask

   task automatic t_mem();
      wr(OFS_MAP, 32'h10008);
      wr(OFS_MEM_PTR, 32'h305);
      wr(OFS_MEM_DATA, 32'hA5);
      wr(OFS_MEM_PTR, 32'h1010);
      wr(OFS_MEM_DATA, 32'h5A);
      pm_addr <= 12'h305;
      dm_addr <= 8'h10;
      repeat (2) @(negedge clk_i);
      chk(32'(pm_data), 32'hA5);
      chk(32'(pm_repl), 32'h1);
      chk(32'(dm_data), 32'h5A);
      chk(32'(dm_repl), 32'h1);
      @(posedge clk_i);
      dm_we <= 1'b1;
      pm_addr <= 12'h205;
      @(posedge clk_i);
      dm_we <= 1'b0;
      repeat (2) @(negedge clk_i);
      chk(32'(pm_repl), 32'h0);
      chk(32'(dm_data), 32'h3C);
      wr(OFS_MEM_PTR, 32'h305);
      rd(OFS_MEM_DATA, 32'hA5);
   endtask

   // a hung handshake ends the run here
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         final_report();
      end
   end

   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_break();
      t_match();
      t_mem();
      final_report();
   end
endmodule
`default_nettype wire
